/* hdl/isa_slave_pkg.sv */
// Constants for the ISA slave bus interface: decode spans, block codes, defaults.
// Assumes a single 50 MHz clock; all ISA pins are asynchronous to it.
package isa_slave_pkg;
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned DMA_PAIRS    = 3;
  localparam int unsigned IRQ_OUTS     = 6;
  localparam int unsigned FIFO_DEPTH   = 16;
  // Decode windows, in bytes, above each base address
  localparam logic [11:0] CODEC_SPAN   = 12'h004;
  localparam logic [11:0] SYNTH_SPAN   = 12'h004;
  localparam logic [11:0] PERIPH_SPAN  = 12'h008;
  // Upper address field position on the shared pins
  localparam int unsigned UPPER_LSB    = 12;
  // Strap value after reset: upper address mode
  localparam logic        STRAP_RESET  = 1'b1;
  // Default host channel for each request/acknowledge pair
  localparam logic [8:0]  DMA_MAP_DEFAULT = {3'h3, 3'h1, 3'h0};
  // Default host interrupt line for each output, first output lowest
  localparam logic [23:0] IRQ_MAP_DEFAULT = {4'hf, 4'hc, 4'hb, 4'h9, 4'h7, 4'h5};
  typedef enum logic [1:0] {
    SEL_NONE  = 2'h0,
    SEL_CODEC = 2'h1,
    SEL_SYNTH = 2'h2,
    SEL_PERIPH = 2'h3
  } block_sel_e;
endpackage

/* hdl/fifo_if.sv */
// Carrier between the bus front end and its byte FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fifo_if #(parameter int unsigned WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport writer (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
  modport buffer (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
endinterface

/* hdl/isa_byte_fifo.sv */
// Byte FIFO with registered read data, first word shown ahead.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module isa_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  fifo_if.buffer    f
);
  localparam int unsigned MEM = DEPTH - 1;
  localparam int unsigned PW  = $clog2(DEPTH);

  // Refuse shapes the pointer wrap cannot serve
  if (DEPTH < 4 || WIDTH < 1) begin : g_bad_shape
    $error("isa_byte_fifo: DEPTH must be at least 4 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem [MEM];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;
  logic             push;
  logic             load;

  // One word lives in the output register, the rest in memory
  assign f.push_ready = (count != (PW+1)'(MEM));
  assign push = f.push_valid && f.push_ready;
  assign load = (count != '0) && (!f.pop_valid || f.pop_ready);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= f.push_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == PW'(MEM - 1)) ? '0 : wptr + 1'b1;
      end
      if (load) begin
        rptr <= (rptr == PW'(MEM - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(load);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      f.pop_valid <= 1'b0;
      f.pop_data  <= '0;
    end else if (load) begin
      f.pop_valid <= 1'b1;
      f.pop_data  <= mem[rptr];
    end else if (f.pop_ready) begin
      f.pop_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  fifo_no_overrun_a: assert property (count <= (PW+1)'(MEM))
    else $error("fifo word count beyond memory capacity");
endmodule // isa_byte_fifo

/* hdl/isa_slave_bus_interface.sv */
// ISA slave front end: I/O decode, strobes, wait states, DMA pairs, interrupts, synth select.
// Assumes every ISA pin is asynchronous; configuration ports come from same-clock logic.
// Overview of operation
// - Low twelve address bits select internal block
// - Upper mode: accept decode only if upper zero
// - Strap sampled at bus reset fall
// - Peripheral read disable stops data drive
// - Serial port use suppresses peripheral reads
// - Address enable low I/O, high DMA
// - Read strobe returns register or DMA data
// - Write strobe goes to codec or synth register, or DMA
// - Pull ready low until able to respond
// - Request held until transfer bytes done
// - Default channels 0,1,3; map is loadable
// - Acknowledge latches or drives data bus
// - Interrupt outputs driven only when enabled
// - Default interrupt lines 5,7,9,11,12,15; loadable
// - Synth select low on external synth hit
// - Internal synth enabled frees synth select
// - Volume enable makes synth select volume-up
`timescale 1ns/1ps
module isa_slave_bus_interface (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // ISA bus
  input  wire logic        BUS_RESET_I,
  input  wire logic [15:0] SA_I,
  input  wire logic        AEN_I,
  input  wire logic        IOR_N_I,
  input  wire logic        IOW_N_I,
  input  wire logic [7:0]  SD_I,
  output logic      [7:0]  SD_O,
  output logic             SD_OE_O,
  output logic             CHRDY_O,
  output logic             CHRDY_OE_O,
  output logic      [2:0]  DMA_REQUEST_LINES_O,
  input  wire logic [2:0]  DMA_ACKNOWLEDGE_INPUTS_N_I,
  output logic      [5:0]  IRQ_O,
  output logic      [5:0]  IRQ_OE_O,
  // Peripheral port pins
  input  wire logic        PERIPHERAL_READ_STROBE_I,
  output logic             PERIPHERAL_READ_STROBE_N_O,
  output logic             PERIPHERAL_READ_STROBE_OE_O,
  input  wire logic        SYNTH_CHIP_SELECT_I,
  output logic             SYNTH_CHIP_SELECT_N_O,
  output logic             SYNTH_CHIP_SELECT_OE_O,
  input  wire logic [7:0]  PERIPHERAL_DATA_PINS_I,
  // Configuration
  input  wire logic [11:0] CODEC_BASE_I,
  input  wire logic [11:0] SYNTH_BASE_I,
  input  wire logic [11:0] PERIPH_BASE_I,
  input  wire logic        PERIPHERAL_READ_DISABLE_I,
  input  wire logic        SERIAL_PORT_SWITCH_I,
  input  wire logic        SERIAL_PORT_ENABLE_I,
  input  wire logic        WAVETABLE_PORT_ENABLE_I,
  input  wire logic        INTERNAL_SYNTH_ENABLE_I,
  input  wire logic        VOLUME_CONTROL_ENABLE_I,
  input  wire logic [5:0]  IRQ_ENABLE_I,
  input  wire logic        MAP_LOAD_I,
  input  wire logic [8:0]  DMA_MAP_I,
  input  wire logic [23:0] IRQ_MAP_I,
  // Status
  output logic             UPPER_ADDR_MODE_O,
  output logic             VOLUME_UP_O,
  output logic      [8:0]  DMA_MAP_O,
  output logic      [23:0] IRQ_MAP_O,
  // Register side
  output logic             REG_WR_O,
  output logic             REG_RD_O,
  output logic      [1:0]  REG_SEL_O,
  output logic      [11:0] REG_ADDR_O,
  output logic      [7:0]  REG_WDATA_O,
  input  wire logic [7:0]  REG_RDATA_I,
  input  wire logic        REG_RVALID_I,
  // DMA and interrupt side
  input  wire logic [2:0]  DMA_START_I,
  input  wire logic [2:0]  DMA_BYTES_I,
  input  wire logic [7:0]  DMA_RD_DATA_I,
  input  wire logic [5:0]  IRQ_EVENT_I,
  output logic             CAPTURE_VALID_O,
  output logic      [7:0]  CAPTURE_DATA_O,
  input  wire logic        CAPTURE_READY_I
);
  localparam int unsigned SYN_W = 41;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RDWAIT = 4'b0010,
    ST_PUSH   = 4'b0100,
    ST_HOLD   = 4'b1000
  } cycle_state_e;

  fifo_if #(.WIDTH(isa_slave_pkg::DATA_W)) cap ();

  isa_byte_fifo #(
    .WIDTH (isa_slave_pkg::DATA_W),
    .DEPTH (isa_slave_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .f       (cap.buffer)
  );

  // Two-stage synchroniser for every pin input
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic [SYN_W-1:0] sync_raw;
  assign sync_raw = {SYNTH_CHIP_SELECT_I, PERIPHERAL_DATA_PINS_I, PERIPHERAL_READ_STROBE_I,
                     BUS_RESET_I, DMA_ACKNOWLEDGE_INPUTS_N_I, IOW_N_I, IOR_N_I, AEN_I,
                     SD_I, SA_I};
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1 <= {1'b1, 8'h00, 1'b1, 1'b0, 3'h7, 1'b1, 1'b1, 1'b0, 8'h00, 16'h0000};
      sync2 <= {1'b1, 8'h00, 1'b1, 1'b0, 3'h7, 1'b1, 1'b1, 1'b0, 8'h00, 16'h0000};
    end else begin
      sync1 <= sync_raw;
      sync2 <= sync1;
    end
  end

  logic [15:0] sa_s;
  logic [7:0]  sd_s;
  logic        aen_s;
  logic        ior_n_s;
  logic        iow_n_s;
  logic [2:0]  dack_n_s;
  logic        bres_s;
  logic        strap_s;
  logic [7:0]  pdp_s;
  logic        vol_n_s;
  assign sa_s     = sync2[15:0];
  assign sd_s     = sync2[23:16];
  assign aen_s    = sync2[24];
  assign ior_n_s  = sync2[25];
  assign iow_n_s  = sync2[26];
  assign dack_n_s = sync2[29:27];
  assign bres_s   = sync2[30];
  assign strap_s  = sync2[31];
  assign pdp_s    = sync2[39:32];
  assign vol_n_s  = sync2[40];

  // Strobe and bus reset edges
  logic ior_n_d;
  logic iow_n_d;
  logic bres_d;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ior_n_d <= 1'b1;
      iow_n_d <= 1'b1;
      bres_d  <= 1'b0;
    end else begin
      ior_n_d <= ior_n_s;
      iow_n_d <= iow_n_s;
      bres_d  <= bres_s;
    end
  end
  logic rd_start;
  logic wr_start;
  assign rd_start = ior_n_d && !ior_n_s;
  assign wr_start = iow_n_d && !iow_n_s;

  // strap caught at bus reset release
  logic upper_mode;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      upper_mode <= isa_slave_pkg::STRAP_RESET;
    end else if (bres_d && !bres_s) begin
      upper_mode <= strap_s;
    end
  end

  function automatic logic in_window(input logic [11:0] a, input logic [11:0] base,
                                     input logic [11:0] span);
    logic [11:0] off;
    off = a - base;
    return (a >= base) && (off < span);
  endfunction

  // upper bits must be zero in upper mode
  logic upper_ok;
  assign upper_ok = !upper_mode || (sa_s[15:isa_slave_pkg::UPPER_LSB] == 4'h0);

  logic io_cycle;
  logic dma_cycle;
  assign io_cycle  = !aen_s;
  assign dma_cycle = aen_s && (dack_n_s != 3'h7);

  logic [1:0] hit_sel;
  always_comb begin
    hit_sel = isa_slave_pkg::SEL_NONE;
    // no register decode while address enable high
    if (io_cycle && upper_ok) begin
      if (in_window(sa_s[11:0], CODEC_BASE_I, isa_slave_pkg::CODEC_SPAN)) begin
        hit_sel = isa_slave_pkg::SEL_CODEC;
      end else if (in_window(sa_s[11:0], SYNTH_BASE_I, isa_slave_pkg::SYNTH_SPAN)) begin
        hit_sel = isa_slave_pkg::SEL_SYNTH;
      end else if (in_window(sa_s[11:0], PERIPH_BASE_I, isa_slave_pkg::PERIPH_SPAN)) begin
        hit_sel = isa_slave_pkg::SEL_PERIPH;
      end
    end
  end

  // configuration disables peripheral reads; serial pin use
  logic periph_rd_block;
  assign periph_rd_block = PERIPHERAL_READ_DISABLE_I || SERIAL_PORT_SWITCH_I ||
                           SERIAL_PORT_ENABLE_I || WAVETABLE_PORT_ENABLE_I;

  logic ext_synth;
  assign ext_synth = !INTERNAL_SYNTH_ENABLE_I && !VOLUME_CONTROL_ENABLE_I;

  // DMA channel picked from the lowest active acknowledge
  logic [1:0] dma_ch;
  always_comb begin
    dma_ch = 2'h0;
    if (!dack_n_s[2]) dma_ch = 2'h2;
    if (!dack_n_s[1]) dma_ch = 2'h1;
    if (!dack_n_s[0]) dma_ch = 2'h0;
  end

  cycle_state_e state;
  logic [1:0]   cur_sel;
  logic [2:0]   cnt [3];

  // Bus cycle sequencing
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state       <= ST_IDLE;
      cur_sel     <= isa_slave_pkg::SEL_NONE;
      REG_WR_O    <= 1'b0;
      REG_RD_O    <= 1'b0;
      REG_SEL_O   <= 2'h0;
      REG_ADDR_O  <= 12'h000;
      REG_WDATA_O <= 8'h00;
      SD_O        <= 8'h00;
      SD_OE_O     <= 1'b0;
      cap.push_valid <= 1'b0;
      cap.push_data  <= 8'h00;
    end else begin
      REG_WR_O <= 1'b0;
      REG_RD_O <= 1'b0;
      case (state)
        ST_IDLE: begin
          cur_sel <= hit_sel;
          if (dma_cycle && wr_start) begin
            // acknowledge with write latches the bus byte
            cap.push_valid <= 1'b1;
            cap.push_data  <= sd_s;
            state          <= ST_PUSH;
          end else if (dma_cycle && rd_start) begin
            // read returns DMA data; drive on acknowledge
            SD_O    <= DMA_RD_DATA_I;
            SD_OE_O <= 1'b1;
            state   <= ST_HOLD;
          end else if (wr_start && hit_sel != isa_slave_pkg::SEL_NONE) begin
            // write strobe reaches a codec or synth control register; none for peripheral
            REG_WR_O    <= (hit_sel != isa_slave_pkg::SEL_PERIPH);
            REG_SEL_O   <= hit_sel;
            REG_ADDR_O  <= sa_s[11:0];
            REG_WDATA_O <= sd_s;
            state       <= ST_HOLD;
          end else if (rd_start && hit_sel == isa_slave_pkg::SEL_PERIPH) begin
            SD_O    <= pdp_s;
            SD_OE_O <= !periph_rd_block;
            state   <= ST_HOLD;
          end else if (rd_start && hit_sel != isa_slave_pkg::SEL_NONE) begin
            REG_RD_O   <= 1'b1;
            REG_SEL_O  <= hit_sel;
            REG_ADDR_O <= sa_s[11:0];
            state      <= ST_RDWAIT;
          end
        end
        ST_RDWAIT: begin
          if (REG_RVALID_I) begin
            SD_O    <= REG_RDATA_I;
            SD_OE_O <= 1'b1;
            state   <= ST_HOLD;
          end
        end
        ST_PUSH: begin
          if (cap.push_ready) begin
            cap.push_valid <= 1'b0;
            state          <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (ior_n_s && iow_n_s) begin
            SD_OE_O <= 1'b0;
            cur_sel <= isa_slave_pkg::SEL_NONE;
            state   <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // hold ready low until data or buffer room; host waits on it
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CHRDY_OE_O <= 1'b0;
    end else begin
      CHRDY_OE_O <= (state == ST_RDWAIT && !REG_RVALID_I) ||
                    (state == ST_IDLE && (rd_start || wr_start) &&
                     (dma_cycle ? wr_start : hit_sel == isa_slave_pkg::SEL_CODEC ||
                      hit_sel == isa_slave_pkg::SEL_SYNTH) && !(dma_cycle && !wr_start)) ||
                    (state == ST_PUSH && !cap.push_ready);
    end
  end
  assign CHRDY_O = 1'b0;

  // request held until the transfer's bytes have moved
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      cnt[0] <= 3'h0;
      cnt[1] <= 3'h0;
      cnt[2] <= 3'h0;
      DMA_REQUEST_LINES_O <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (DMA_START_I[i]) begin
          cnt[i] <= DMA_BYTES_I;
        end else if (state == ST_IDLE && dma_cycle && (rd_start || wr_start) &&
                     dma_ch == 2'(i) && cnt[i] != 3'h0) begin
          cnt[i] <= cnt[i] - 3'h1;
        end
        DMA_REQUEST_LINES_O[i] <= (cnt[i] != 3'h0);
      end
    end
  end

  // channel map defaults, loadable; interrupt map likewise
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      DMA_MAP_O <= isa_slave_pkg::DMA_MAP_DEFAULT;
      IRQ_MAP_O <= isa_slave_pkg::IRQ_MAP_DEFAULT;
    end else if (MAP_LOAD_I) begin
      DMA_MAP_O <= DMA_MAP_I;
      IRQ_MAP_O <= IRQ_MAP_I;
    end
  end

  // each interrupt output driven only when enabled
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      IRQ_O    <= 6'h00;
      IRQ_OE_O <= 6'h00;
    end else begin
      IRQ_O    <= IRQ_EVENT_I & IRQ_ENABLE_I;
      IRQ_OE_O <= IRQ_ENABLE_I;
    end
  end

  // Peripheral pins: strobe released during bus reset so the strap can be read
  logic cycle_active;
  assign cycle_active = (state != ST_IDLE);
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      PERIPHERAL_READ_STROBE_N_O  <= 1'b1;
      PERIPHERAL_READ_STROBE_OE_O <= 1'b0;
      SYNTH_CHIP_SELECT_N_O       <= 1'b1;
      SYNTH_CHIP_SELECT_OE_O      <= 1'b0;
      VOLUME_UP_O                 <= 1'b0;
      UPPER_ADDR_MODE_O           <= isa_slave_pkg::STRAP_RESET;
    end else begin
      PERIPHERAL_READ_STROBE_OE_O <= !bres_s;
      PERIPHERAL_READ_STROBE_N_O  <= !(cycle_active && !ior_n_s &&
                                       (cur_sel == isa_slave_pkg::SEL_PERIPH ||
                                        (cur_sel == isa_slave_pkg::SEL_SYNTH && ext_synth)));
      // select low on external synth hit; internal synth frees it
      SYNTH_CHIP_SELECT_N_O  <= !(cycle_active && ext_synth &&
                                  cur_sel == isa_slave_pkg::SEL_SYNTH);
      // volume enable turns the pin into an input
      SYNTH_CHIP_SELECT_OE_O <= !VOLUME_CONTROL_ENABLE_I;
      VOLUME_UP_O            <= VOLUME_CONTROL_ENABLE_I && !vol_n_s;
      UPPER_ADDR_MODE_O      <= upper_mode;
    end
  end

  assign cap.pop_ready   = CAPTURE_READY_I;
  assign CAPTURE_VALID_O = cap.pop_valid;
  assign CAPTURE_DATA_O  = cap.pop_data;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  ready_on_read_a: assert property (state == ST_RDWAIT && !REG_RVALID_I |=> CHRDY_OE_O)
    else $error("ready not held low while read data pending");
  io_only_write_a: assert property (REG_WR_O |-> $past(!aen_s))
    else $error("register write during a DMA cycle");
  upper_alias_a: assert property ((REG_RD_O || REG_WR_O) && upper_mode
                                  |-> $past(sa_s[15:12] == 4'h0))
    else $error("decode accepted with upper bits set");
  periph_gate_a: assert property ($rose(SD_OE_O) && cur_sel == isa_slave_pkg::SEL_PERIPH
                                  |-> !$past(periph_rd_block))
    else $error("peripheral read driven while suppressed");
  irq_gate_a: assert property (##1 (IRQ_O & ~IRQ_OE_O) == 6'h00 &&
                               IRQ_OE_O == $past(IRQ_ENABLE_I))
    else $error("interrupt driven while disabled");
  req_hold_a: assert property ($fell(DMA_REQUEST_LINES_O[0]) |-> $past(cnt[0], 2) <= 3'h1)
    else $error("request dropped before bytes moved");
  synth_free_a: assert property (INTERNAL_SYNTH_ENABLE_I ##1 INTERNAL_SYNTH_ENABLE_I
                                 |-> SYNTH_CHIP_SELECT_N_O)
    else $error("synth select used while internal synth on");
  vol_input_a: assert property (VOLUME_CONTROL_ENABLE_I |=> !SYNTH_CHIP_SELECT_OE_O)
    else $error("synth pin driven in volume mode");
  push_wait_a: assert property (state == ST_PUSH && !cap.push_ready |=> CHRDY_OE_O)
    else $error("full buffer did not stretch the cycle");
endmodule // isa_slave_bus_interface

/* tb/isa_host_model.sv */
// ISA host and DMA controller model: one bus cycle at a time.
// Assumes the slave's data and ready enables are high while it drives.
`timescale 1ns/1ps
module isa_host_model (
  // Clock
  input  wire logic        clk_i,
  // Host-driven pins
  output logic      [15:0] sa_o,
  output logic             aen_o,
  output logic             ior_n_o,
  output logic             iow_n_o,
  output logic      [7:0]  sd_o,
  output logic      [2:0]  dack_n_o,
  // Slave answers
  input  wire logic [7:0]  sd_i,
  input  wire logic        sd_oe_i,
  input  wire logic        chrdy_oe_i
);
  int hangs = 0;
  initial begin
    {sa_o, aen_o, sd_o} = '0;
    {ior_n_o, iow_n_o, dack_n_o} = '1;
  end
  // Acknowledge index 3 means a DMA-type cycle with no acknowledge
  task automatic cyc(input logic rd, input logic dma, input int ack, input logic [15:0] a,
                     input logic [7:0] wd, output logic [8:0] got, output int held);
    int n;
    @(negedge clk_i);
    sa_o = a;
    aen_o = dma;
    sd_o = wd;
    if (dma && ack < 3) dack_n_o[ack] = 1'b0;
    if (rd) ior_n_o = 1'b0;
    else iow_n_o = 1'b0;
    held = 0;
    for (n = 0; n < 8 || chrdy_oe_i === 1'b1; n++) begin
      @(negedge clk_i);
      held += int'(chrdy_oe_i === 1'b1);
      if (n > 400) begin
        hangs++;
        break;
      end
    end
    got = {sd_oe_i, sd_i};
    {ior_n_o, iow_n_o, dack_n_o} = '1;
    aen_o = 1'b0;
    sd_o = ~wd;
    repeat (6) @(negedge clk_i);
  endtask
endmodule // isa_host_model

/* tb/isa_slave_bus_interface_tb_top.sv */
// Self-checking bench for the ISA slave front end.
// Assumes the host model drives the bus and the bench answers register reads.
`timescale 1ns/1ps
module isa_slave_bus_interface_tb_top;
  logic CLK_I, RESET_I, BUS_RESET_I, AEN_I, IOR_N_I, IOW_N_I, SD_OE_O, CHRDY_O, CHRDY_OE_O;
  logic PERIPHERAL_READ_STROBE_N_O, PERIPHERAL_READ_STROBE_OE_O, SYNTH_CHIP_SELECT_N_O;
  logic SYNTH_CHIP_SELECT_OE_O, PERIPHERAL_READ_DISABLE_I, SERIAL_PORT_SWITCH_I;
  logic SERIAL_PORT_ENABLE_I, WAVETABLE_PORT_ENABLE_I, INTERNAL_SYNTH_ENABLE_I;
  logic VOLUME_CONTROL_ENABLE_I, MAP_LOAD_I, UPPER_ADDR_MODE_O, VOLUME_UP_O, REG_WR_O;
  logic REG_RD_O, CAPTURE_VALID_O, CAPTURE_READY_I, strap_pin, vol_pin;
  logic REG_RVALID_I = 1'b0;
  logic [15:0] SA_I;
  logic [11:0] CODEC_BASE_I, SYNTH_BASE_I, PERIPH_BASE_I, REG_ADDR_O;
  logic [8:0] DMA_MAP_I, DMA_MAP_O, got;
  logic [23:0] IRQ_MAP_I, IRQ_MAP_O;
  logic [7:0] SD_I, SD_O, PERIPHERAL_DATA_PINS_I, REG_WDATA_O, REG_RDATA_I, DMA_RD_DATA_I;
  logic [7:0] CAPTURE_DATA_O, cap_q[$], exp_q[$];
  logic [5:0] IRQ_O, IRQ_OE_O, IRQ_ENABLE_I, IRQ_EVENT_I;
  logic [2:0] DMA_REQUEST_LINES_O, DMA_ACKNOWLEDGE_INPUTS_N_I, DMA_START_I, DMA_BYTES_I;
  logic [1:0] REG_SEL_O;
  logic scs_seen, prs_seen;
  int fail_count = 0, samples_checked = 0, wr_n = 0, rv_cnt = 0, held, i;
  // Shared pins resolve from the drive enable, else the board level
  wire PERIPHERAL_READ_STROBE_I = PERIPHERAL_READ_STROBE_OE_O ? PERIPHERAL_READ_STROBE_N_O
                                                              : strap_pin;
  wire SYNTH_CHIP_SELECT_I = SYNTH_CHIP_SELECT_OE_O ? SYNTH_CHIP_SELECT_N_O : vol_pin;

  isa_slave_bus_interface dut_u (.*);
  isa_host_model host_u (.clk_i(CLK_I), .sa_o(SA_I), .aen_o(AEN_I), .ior_n_o(IOR_N_I),
    .iow_n_o(IOW_N_I), .sd_o(SD_I), .dack_n_o(DMA_ACKNOWLEDGE_INPUTS_N_I), .sd_i(SD_O),
    .sd_oe_i(SD_OE_O), .chrdy_oe_i(CHRDY_OE_O));

  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (REG_WR_O === 1'b1) wr_n++;
    if (SYNTH_CHIP_SELECT_N_O === 1'b0 && SYNTH_CHIP_SELECT_OE_O === 1'b1) scs_seen = 1'b1;
    if (PERIPHERAL_READ_STROBE_N_O === 1'b0 && PERIPHERAL_READ_STROBE_OE_O === 1'b1) begin
      prs_seen = 1'b1;
    end
    if (CAPTURE_VALID_O === 1'b1 && CAPTURE_READY_I === 1'b1) cap_q.push_back(CAPTURE_DATA_O);
  end
  // Register read answer three cycles after the read pulse
  always @(negedge CLK_I) begin
    REG_RVALID_I <= (rv_cnt == 1);
    if (REG_RD_O === 1'b1) rv_cnt <= 3;
    else if (rv_cnt > 0) rv_cnt <= rv_cnt - 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    fail_count += host_u.hangs;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d);
    host_u.cyc(rd, 1'b0, 0, a, d, got, held);
  endtask
  task automatic dw(input int ack, input logic [7:0] d);
    exp_q.push_back(d);
    host_u.cyc(1'b0, 1'b1, ack, 16'h0000, d, got, held);
  endtask

  initial begin
    {BUS_RESET_I, PERIPHERAL_DATA_PINS_I, PERIPHERAL_READ_DISABLE_I, SERIAL_PORT_SWITCH_I} = '0;
    {SERIAL_PORT_ENABLE_I, WAVETABLE_PORT_ENABLE_I, INTERNAL_SYNTH_ENABLE_I} = '0;
    {VOLUME_CONTROL_ENABLE_I, IRQ_ENABLE_I, MAP_LOAD_I, DMA_MAP_I, IRQ_MAP_I} = '0;
    {REG_RDATA_I, DMA_START_I, DMA_BYTES_I, DMA_RD_DATA_I, IRQ_EVENT_I, CAPTURE_READY_I} = '0;
    {strap_pin, vol_pin, scs_seen} = 3'h6;
    CODEC_BASE_I = 12'h534;
    SYNTH_BASE_I = 12'h388;
    PERIPH_BASE_I = 12'h200;
    RESET_I = 1'b1;
    repeat (4) @(negedge CLK_I);
    RESET_I = 1'b0;
    repeat (3) @(negedge CLK_I);
    chk("dma_map", DMA_MAP_O, {3'h3, 3'h1, 3'h0});
    chk("irq_map", IRQ_MAP_O, {4'hf, 4'hc, 4'hb, 4'h9, 4'h7, 4'h5});
    chk("upper_mode", UPPER_ADDR_MODE_O, 1'b1);
    {DMA_MAP_I, IRQ_MAP_I, MAP_LOAD_I} = {9'h0ab, 24'h123456, 1'b1};
    @(negedge CLK_I);
    MAP_LOAD_I = 1'b0;
    @(negedge CLK_I);
    chk("dma_map", DMA_MAP_O, 9'h0ab);
    chk("irq_map", IRQ_MAP_O, 24'h123456);
    io(1'b0, 16'h0535, 8'hc3);
    chk("wr_pulses", wr_n, 1);
    chk("reg_sel", {REG_SEL_O, REG_ADDR_O, REG_WDATA_O}, {2'h1, 12'h535, 8'hc3});
    REG_RDATA_I = 8'h96;
    io(1'b1, 16'h0536, 8'h00);
    chk("rd_data", got, {1'b1, 8'h96});
    chk("ready_low", {CHRDY_O, held > 0}, 2'h1);
    host_u.cyc(1'b0, 1'b1, 3, 16'h0535, 8'h44, got, held);
    chk("wr_pulses", wr_n, 1);
    io(1'b0, 16'h1535, 8'h22);
    chk("wr_pulses", wr_n, 1);
    {strap_pin, BUS_RESET_I} = 2'h1;
    repeat (4) @(negedge CLK_I);
    chk("strobe_oe", PERIPHERAL_READ_STROBE_OE_O, 1'b0);
    BUS_RESET_I = 1'b0;
    repeat (6) @(negedge CLK_I);
    chk("upper_mode", UPPER_ADDR_MODE_O, 1'b0);
    strap_pin = 1'b1;
    io(1'b0, 16'h1535, 8'h22);
    chk("wr_pulses", wr_n, 2);
    PERIPHERAL_DATA_PINS_I = 8'h5c;
    for (i = 0; i < 5; i++) begin
      {WAVETABLE_PORT_ENABLE_I, SERIAL_PORT_ENABLE_I, SERIAL_PORT_SWITCH_I,
       PERIPHERAL_READ_DISABLE_I} = (i == 0) ? 4'h0 : 4'(4'h1 << (i - 1));
      prs_seen = 1'b0;
      io(1'b1, 16'h0203, 8'h00);
      chk("periph_strobe", prs_seen, 1'b1);
      chk("periph_rd", (i == 0) ? got : got[8], (i == 0) ? {1'b1, 8'h5c} : 9'h000);
    end
    {WAVETABLE_PORT_ENABLE_I, SERIAL_PORT_ENABLE_I} = 2'h0;
    for (i = 0; i < 3; i++) begin
      {VOLUME_CONTROL_ENABLE_I, INTERNAL_SYNTH_ENABLE_I} = 2'(i);
      scs_seen = 1'b0;
      io(1'b0, 16'h0389, 8'h01);
      chk("synth_sel", scs_seen, i == 0);
    end
    vol_pin = 1'b0;
    repeat (5) @(negedge CLK_I);
    chk("volume_up", VOLUME_UP_O, 1'b1);
    {vol_pin, VOLUME_CONTROL_ENABLE_I, IRQ_ENABLE_I, IRQ_EVENT_I} = {2'h2, 6'h25, 6'h3f};
    repeat (5) @(negedge CLK_I);
    chk("irq", {IRQ_OE_O, IRQ_O}, {6'h25, 6'h25});
    {DMA_BYTES_I, DMA_START_I} = {3'h2, 3'h1};
    @(negedge CLK_I);
    DMA_START_I = 3'h0;
    repeat (3) @(negedge CLK_I);
    chk("dma_req", DMA_REQUEST_LINES_O, 3'h1);
    dw(0, 8'h11);
    chk("dma_req", DMA_REQUEST_LINES_O, 3'h1);
    dw(0, 8'h22);
    chk("dma_req", DMA_REQUEST_LINES_O, 3'h0);
    DMA_RD_DATA_I = 8'ha7;
    host_u.cyc(1'b1, 1'b1, 1, 16'h0000, 8'h00, got, held);
    chk("dma_rd", got, {1'b1, 8'ha7});
    for (i = 0; i < 14; i++) dw(2, 8'(8'h30 + i));
    fork
      dw(0, 8'h3e);
      begin
        repeat (30) @(negedge CLK_I);
        CAPTURE_READY_I = 1'b1;
        @(negedge CLK_I);
        CAPTURE_READY_I = 1'b0;
      end
    join
    chk("full_stall", held > 20, 1);
    CAPTURE_READY_I = 1'b1;
    repeat (40) @(negedge CLK_I);
    chk("cap_count", cap_q.size(), exp_q.size());
    foreach (exp_q[k]) chk("cap_data", (k < cap_q.size()) ? cap_q[k] : 8'hxx, exp_q[k]);
    report_and_stop();
  end
endmodule // isa_slave_bus_interface_tb_top
